// ===== logic/ars_pkg.sv
// restart supervisor constants, register map, mode codes and carriers
// assumes a 200 MHz mclk and a 32-bit APB slave port
package ars_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned TICK_TIME_MS = 100;
  localparam int unsigned TICK_CYCLES = TICK_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned SUP_TIME_DEF_S = 60;
  localparam logic [15:0] SUP_TIME_DEF = 16'(SUP_TIME_DEF_S * 1000 / TICK_TIME_MS);
  localparam logic [15:0] WIN_TIME_DEF = 16'h0000;
  localparam logic [7:0] LIMIT_DEF = 8'h03;
  localparam int unsigned LIST_N = 10;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SUPTIME = 8'h04;
  localparam logic [7:0] ADDR_WINTIME = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
  localparam logic [7:0] ADDR_LIST = 8'h20;
  localparam int unsigned CTRL_MODE_POS = 0;
  localparam int unsigned CTRL_LIMIT_POS = 8;
  localparam int unsigned ST_FAILED_POS = 3;
  localparam int unsigned ST_SPARE_POS = 4;
  localparam int unsigned ST_CNT_POS = 8;
  localparam int unsigned ST_SUCC_POS = 16;
  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_START = 1;
  localparam int unsigned IRQ_FAILED = 2;
  localparam int unsigned IRQ_W = 3;

  localparam logic [4:0] MODE_OFF = 5'h00;
  localparam logic [4:0] MODE_ACK = 5'h01;
  localparam logic [4:0] MODE_POWER = 5'h04;
  localparam logic [4:0] MODE_FAULT = 5'h06;
  localparam logic [4:0] MODE_POWER_MAN = 5'h0e;
  localparam logic [4:0] MODE_FAULT_MAN = 5'h10;
  localparam logic [4:0] MODE_RUN = 5'h1a;

  typedef enum logic [2:0] {ST_IDLE, ST_ACKWAIT, ST_RUNWAIT, ST_RESTART, ST_LOCKED} ars_state_type;

  typedef struct packed {
    logic powerLoss;
    logic [15:0] number;
  } ars_fault_type;

  function automatic logic isSupervised(input logic [4:0] m);
    return m == MODE_POWER || m == MODE_FAULT || m == MODE_POWER_MAN ||
           m == MODE_FAULT_MAN || m == MODE_RUN;
  endfunction

  function automatic logic listActive(input logic [4:0] m);
    return m == MODE_FAULT || m == MODE_FAULT_MAN || m == MODE_RUN;
  endfunction

  function automatic logic isPowerOnly(input logic [4:0] m);
    return m == MODE_POWER || m == MODE_POWER_MAN;
  endfunction

  function automatic logic isManual(input logic [4:0] m);
    return m == MODE_POWER_MAN || m == MODE_FAULT_MAN;
  endfunction
endpackage

// ===== logic/ars_tick.sv
// fixed time-base tick for the supervision timers
// assumes one clock domain; clkEn freezes the prescaler
`timescale 1ns/100ps
module ars_tick
#(
  parameter int unsigned CYCLES = ars_pkg::TICK_CYCLES
)
(
  input wire logic mclk, // device clock
  input wire logic rst_n, // async reset
  input wire logic clkEn, // clock enable
  output logic tick // one-cycle time-base pulse
);
  localparam int unsigned CW = $clog2(CYCLES);

  if (CYCLES < 2)
  begin : g_chk
    $error("tick period too short");
  end

  logic [CW-1:0] countReg;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      countReg <= '0;
      tick <= 1'b0;
    end
    else if (clkEn)
    begin
      tick <= countReg == CW'(CYCLES - 1);
      countReg <= (countReg == CW'(CYCLES - 1)) ? '0 : countReg + 1'b1;
    end
  end
endmodule

// ===== logic/ars_timer.sv
// tick-counting supervision timer with start, stop and expiry pulse
// assumes tick from ars_tick; duration sampled while running
`timescale 1ns/100ps
module ars_timer
#(
  parameter int unsigned W = 16
)
(
  input wire logic mclk, // device clock
  input wire logic rst_n, // async reset
  input wire logic clkEn, // clock enable
  input wire logic tick, // time-base pulse
  input wire logic enable, // timer allowed in this mode
  input wire logic start, // (re)start pulse
  input wire logic stop, // stop pulse
  input wire logic zeroExpires, // zero duration at start expires at once instead of disabling
  input wire logic [W-1:0] duration, // ticks
  output logic running, // timer active
  output logic expired // one-cycle expiry pulse
);
  if (W < 1 || W > 32)
  begin : g_chk
    $error("timer width out of range");
  end

  logic [W-1:0] countReg;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      countReg <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end
    else if (clkEn)
    begin
      expired <= 1'b0;
      if (!enable || stop)
        running <= 1'b0;
      else if (start)
      begin
        countReg <= '0;
        running <= duration != '0;
        expired <= duration == '0 && zeroExpires;
      end
      else if (running && tick)
      begin
        // a zero written mid-run stops the timer without expiry
        if (duration == '0)
          running <= 1'b0;
        else if (countReg + 1'b1 >= duration)
        begin
          running <= 1'b0;
          expired <= 1'b1;
        end
        else
          countReg <= countReg + 1'b1;
      end
    end
  end
endmodule

// ===== logic/ars_supervisor.sv
// automatic restart supervisor: APB registers, restart sequencing,
// attempt counting, supervision and window timers, interrupt
// assumes fault, acknowledge and start signals synchronous to mclk
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
module ars_supervisor
#(
  parameter int unsigned TICK_CYCLES = ars_pkg::TICK_CYCLES,
  parameter int unsigned LIMIT_W = 8,
  parameter int unsigned TIME_W = 16
)
(
  input wire logic mclk, // 200 MHz device clock
  input wire logic rst_n, // async reset
  input wire logic clkEn, // freezes all state while low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic faultValid, // fault detected pulse
  input wire ars_pkg::ars_fault_type fault, // fault number and power-loss flag
  input wire logic ackIn, // operator acknowledge pulse
  input wire logic motorOn, // motor switched on
  input wire logic runCommand, // operator run command level
  input wire logic startOk, // start attempt succeeded pulse
  output logic faultAck, // automatic fault acknowledge pulse
  output logic restartReq, // request motor start
  output logic restartFailedFault, // restart-failed fault level
  output logic irq // interrupt level
);
  if (LIMIT_W < 1 || LIMIT_W > 8 || TIME_W < 1 || TIME_W > 16)
  begin : g_chk
    $error("field widths exceed register layout");
  end

  // ---------------------------------------------------------------
  // registers and bus
  // ---------------------------------------------------------------
  logic [4:0] modeReg;
  logic [LIMIT_W-1:0] limitReg;
  logic [TIME_W-1:0] supTimeReg;
  logic [TIME_W-1:0] winTimeReg;
  logic [15:0] listReg [ars_pkg::LIST_N];
  logic [ars_pkg::IRQ_W-1:0] irqStatReg;
  logic [ars_pkg::IRQ_W-1:0] irqEnReg;
  logic changedReg;
  ars_pkg::ars_state_type stReg;
  logic [LIMIT_W-1:0] cntReg;
  logic spareReg;
  logic [LIMIT_W:0] succReg;
  logic wrEn;
  logic [31:0] rdMux;
  logic rdOk;

  function automatic logic listHit(input logic [7:0] a);
    return a >= ars_pkg::ADDR_LIST && a < ars_pkg::ADDR_LIST + 8'(4 * ars_pkg::LIST_N)
           && a[1:0] == 2'b00;
  endfunction

  function automatic logic [3:0] listIdx(input logic [7:0] a);
    return 4'((a - ars_pkg::ADDR_LIST) >> 2);
  endfunction

  // zero wait states: read data is captured in the setup cycle
  assign pready = clkEn;
  assign wrEn = psel && penable && pwrite && clkEn;

  always_comb
  begin
    rdMux = '0;
    rdOk = 1'b1;
    if (listHit(paddr))
      rdMux[15:0] = listReg[listIdx(paddr)];
    else
      case (paddr)
        ars_pkg::ADDR_CTRL:
        begin
          rdMux[ars_pkg::CTRL_MODE_POS +: 5] = modeReg;
          rdMux[ars_pkg::CTRL_LIMIT_POS +: LIMIT_W] = limitReg;
        end
        ars_pkg::ADDR_SUPTIME: rdMux[TIME_W-1:0] = supTimeReg;
        ars_pkg::ADDR_WINTIME: rdMux[TIME_W-1:0] = winTimeReg;
        ars_pkg::ADDR_STATE:
        begin
          rdMux[2:0] = stReg;
          rdMux[ars_pkg::ST_FAILED_POS] = restartFailedFault;
          rdMux[ars_pkg::ST_SPARE_POS] = spareReg;
          rdMux[ars_pkg::ST_CNT_POS +: LIMIT_W] = cntReg;
          rdMux[ars_pkg::ST_SUCC_POS +: LIMIT_W+1] = succReg;
        end
        ars_pkg::ADDR_IRQ_STAT: rdMux[ars_pkg::IRQ_W-1:0] = irqStatReg;
        ars_pkg::ADDR_IRQ_CLR: rdMux = '0;
        ars_pkg::ADDR_IRQ_EN: rdMux[ars_pkg::IRQ_W-1:0] = irqEnReg;
        default: rdOk = 1'b0;
      endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (clkEn && psel && !penable)
    begin
      prdata <= pwrite ? '0 : rdMux;
      pslverr <= !rdOk;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modeReg <= ars_pkg::MODE_OFF;
      limitReg <= LIMIT_W'(ars_pkg::LIMIT_DEF);
      supTimeReg <= TIME_W'(ars_pkg::SUP_TIME_DEF);
      winTimeReg <= TIME_W'(ars_pkg::WIN_TIME_DEF);
      irqEnReg <= '0;
      changedReg <= 1'b0;
      for (int i = 0; i < ars_pkg::LIST_N; i++)
        listReg[i] <= '0;
    end
    else if (clkEn)
    begin
      changedReg <= 1'b0;
      if (wrEn && listHit(paddr))
        listReg[listIdx(paddr)] <= pwdata[15:0];
      else if (wrEn)
        case (paddr)
          ars_pkg::ADDR_CTRL:
          begin
            modeReg <= pwdata[ars_pkg::CTRL_MODE_POS +: 5];
            limitReg <= pwdata[ars_pkg::CTRL_LIMIT_POS +: LIMIT_W];
            changedReg <= pwdata[ars_pkg::CTRL_MODE_POS +: 5] != modeReg ||
              pwdata[ars_pkg::CTRL_LIMIT_POS +: LIMIT_W] != limitReg;
          end
          ars_pkg::ADDR_SUPTIME: supTimeReg <= pwdata[TIME_W-1:0];
          ars_pkg::ADDR_WINTIME: winTimeReg <= pwdata[TIME_W-1:0];
          ars_pkg::ADDR_IRQ_EN: irqEnReg <= pwdata[ars_pkg::IRQ_W-1:0];
          default: ;
        endcase
    end
  end

  // ---------------------------------------------------------------
  // restart decision
  // ---------------------------------------------------------------
  logic tick;
  logic suppressed;
  logic restartable;
  logic exhausted;
  logic idleFault;
  logic doAck;
  logic startAcc;
  logic tooMany;
  logic supExpired;
  logic supRunning;
  logic winExpired;
  logic winRunning;
  logic failNow;
  logic lockClear;
  logic reloadReq;

  always_comb
  begin
    suppressed = 1'b0;
    for (int i = 0; i < ars_pkg::LIST_N; i++)
      if (listReg[i] != '0 && listReg[i] == fault.number)
        suppressed = 1'b1;
  end

  // a listed fieldbus-loss number blocks the mode-6 restart like any other
  assign restartable = ars_pkg::isPowerOnly(modeReg) ? fault.powerLoss :
    ars_pkg::listActive(modeReg) && !suppressed;
  assign exhausted = cntReg == '0 && !spareReg;
  assign idleFault = stReg == ars_pkg::ST_IDLE && faultValid && restartable;
  assign doAck = (idleFault && !ars_pkg::isManual(modeReg)) ||
    (stReg == ars_pkg::ST_ACKWAIT && ackIn);
  assign startAcc = stReg == ars_pkg::ST_RESTART && startOk;
  assign tooMany = startAcc && succReg > (LIMIT_W+1)'(limitReg);
  assign failNow = stReg != ars_pkg::ST_LOCKED &&
    (supExpired || (doAck && exhausted) || tooMany);
  // the motor must be off before the failure may be cleared
  assign lockClear = stReg == ars_pkg::ST_LOCKED && ackIn && !motorOn;
  assign reloadReq = winExpired || lockClear || changedReg;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      stReg <= ars_pkg::ST_IDLE;
    else if (clkEn)
    begin
      if (failNow)
        stReg <= ars_pkg::ST_LOCKED;
      else
        case (stReg)
          ars_pkg::ST_IDLE:
            if (idleFault && ars_pkg::isManual(modeReg))
              stReg <= ars_pkg::ST_ACKWAIT;
            else if (doAck)
              stReg <= modeReg == ars_pkg::MODE_RUN ? ars_pkg::ST_RUNWAIT : ars_pkg::ST_RESTART;
          ars_pkg::ST_ACKWAIT:
            if (doAck)
              stReg <= ars_pkg::ST_RESTART;
          ars_pkg::ST_RUNWAIT:
            if (runCommand)
              stReg <= ars_pkg::ST_RESTART;
          ars_pkg::ST_RESTART:
            if (startOk)
              stReg <= ars_pkg::ST_IDLE;
          ars_pkg::ST_LOCKED:
            if (lockClear)
              stReg <= ars_pkg::ST_IDLE;
          default: stReg <= ars_pkg::ST_IDLE;
        endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cntReg <= LIMIT_W'(ars_pkg::LIMIT_DEF);
      spareReg <= 1'b1;
      succReg <= '0;
    end
    else if (clkEn)
    begin
      // the spare attempt gives limit plus one tries in total
      if (reloadReq)
      begin
        cntReg <= limitReg;
        spareReg <= 1'b1;
      end
      else if (doAck && cntReg != '0)
        cntReg <= cntReg - 1'b1;
      else if (doAck)
        spareReg <= 1'b0;
      if (reloadReq)
        succReg <= '0;
      else if (startAcc && succReg != '1)
        succReg <= succReg + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      faultAck <= 1'b0;
      restartFailedFault <= 1'b0;
    end
    else if (clkEn)
    begin
      faultAck <= (doAck && !exhausted) ||
        (faultValid && modeReg == ars_pkg::MODE_ACK);
      if (failNow)
        restartFailedFault <= 1'b1;
      else if (lockClear)
        restartFailedFault <= 1'b0;
    end
  end

  assign restartReq = stReg == ars_pkg::ST_RESTART;

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  ars_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .tick(tick)
  );

  ars_timer #(.W(TIME_W)) u_sup (
    .mclk(mclk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .tick(tick),
    .enable(ars_pkg::isSupervised(modeReg)),
    .start(idleFault),
    .stop(startAcc || stReg == ars_pkg::ST_LOCKED),
    .zeroExpires(1'b0),
    .duration(supTimeReg),
    .running(supRunning),
    .expired(supExpired)
  );

  ars_timer #(.W(TIME_W)) u_win (
    .mclk(mclk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .tick(tick),
    .enable(ars_pkg::isSupervised(modeReg)),
    .start(startAcc),
    .stop(1'b0),
    .zeroExpires(1'b1),
    .duration(winTimeReg),
    .running(winRunning),
    .expired(winExpired)
  );

  // ---------------------------------------------------------------
  // interrupt: events set, clear register clears, set wins
  // ---------------------------------------------------------------
  logic [ars_pkg::IRQ_W-1:0] irqEv;
  logic [ars_pkg::IRQ_W-1:0] irqClr;

  always_comb
  begin
    irqEv = '0;
    irqEv[ars_pkg::IRQ_FAULT] = faultValid;
    irqEv[ars_pkg::IRQ_START] = startAcc;
    irqEv[ars_pkg::IRQ_FAILED] = failNow;
    irqClr = (wrEn && paddr == ars_pkg::ADDR_IRQ_CLR) ? pwdata[ars_pkg::IRQ_W-1:0] : '0;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irqStatReg <= '0;
    else if (clkEn)
      irqStatReg <= (irqStatReg & ~irqClr) | irqEv;
  end

  assign irq = |(irqStatReg & irqEnReg);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_fail_lock;
    clkEn && failNow |=> stReg == ars_pkg::ST_LOCKED && restartFailedFault && !restartReq;
  endproperty
  a_fail_lock: assert property (p_fail_lock) else $error("failure did not lock");

  property p_sup_off;
    !ars_pkg::isSupervised(modeReg) [*2] |-> !supRunning && !winRunning;
  endproperty
  a_sup_off: assert property (p_sup_off) else $error("timer ran in plain mode");

  property p_zero_sup;
    supTimeReg == '0 && $past(supTimeReg) == '0 |-> !supExpired;
  endproperty
  a_zero_sup: assert property (p_zero_sup) else $error("disabled timer expired");

  property p_decrement;
    clkEn && doAck && !reloadReq && cntReg != '0 |=> cntReg == $past(cntReg) - 1'b1;
  endproperty
  a_decrement: assert property (p_decrement) else $error("attempt count not decremented");

  property p_reload;
    clkEn && reloadReq |=> cntReg == $past(limitReg) && spareReg && succReg == '0;
  endproperty
  a_reload: assert property (p_reload) else $error("attempt count not reloaded");

  property p_suppress;
    clkEn && stReg == ars_pkg::ST_IDLE && faultValid && ars_pkg::listActive(modeReg)
      && suppressed |=> stReg == ars_pkg::ST_IDLE && !supRunning;
  endproperty
  a_suppress: assert property (p_suppress) else $error("listed fault restarted");

  property p_power_list;
    clkEn && stReg == ars_pkg::ST_IDLE && faultValid && modeReg == ars_pkg::MODE_POWER
      && fault.powerLoss && !exhausted |=> restartReq [*2];
  endproperty
  a_power_list: assert property (p_power_list) else $error("list acted in mode 4");

  property p_bus_loss;
    clkEn && stReg == ars_pkg::ST_IDLE && faultValid && modeReg == ars_pkg::MODE_FAULT
      && !suppressed && !exhausted |=> restartReq && faultAck;
  endproperty
  a_bus_loss: assert property (p_bus_loss) else $error("mode 6 fault not restarted");

  property p_too_many;
    clkEn && startAcc && succReg > (LIMIT_W+1)'(limitReg) |=> restartFailedFault;
  endproperty
  a_too_many: assert property (p_too_many) else $error("start count limit missed");

  property p_sup_start;
    clkEn && idleFault && ars_pkg::isSupervised(modeReg) && supTimeReg != '0 |=> supRunning;
  endproperty
  a_sup_start: assert property (p_sup_start) else $error("supervision not started");

  property p_win_start;
    clkEn && startAcc && winTimeReg > TIME_W'(1) && !changedReg |=> winRunning [*2];
  endproperty
  a_win_start: assert property (p_win_start) else $error("window not started");

  property p_ack_only;
    clkEn && faultValid && modeReg == ars_pkg::MODE_ACK && stReg == ars_pkg::ST_IDLE
      |=> faultAck && stReg == ars_pkg::ST_IDLE;
  endproperty
  a_ack_only: assert property (p_ack_only) else $error("mode 1 misbehaved");

  c_timeout: cover property (stReg == ars_pkg::ST_RESTART && supExpired);
  c_too_many: cover property (tooMany);
  c_restart_ok: cover property (startAcc ##1 stReg == ars_pkg::ST_IDLE);
  c_manual: cover property (stReg == ars_pkg::ST_ACKWAIT && ackIn);
endmodule

// ===== verif/ars_partner.sv
// fault source and start sequencer model facing the supervisor
// assumes startOk matters only while restartReq is high
`timescale 1ns/100ps
module ars_partner
(
  input wire logic mclk, // clock
  input wire logic rst_n, // reset
  input wire logic restartReq, // start request
  input wire logic inj, // raise a fault
  input wire ars_pkg::ars_fault_type flt, // fault to raise
  input wire logic [7:0] dly, // start latency
  input wire logic hold, // never succeed
  output logic faultValid, // fault pulse
  output ars_pkg::ars_fault_type fault, // fault data
  output logic startOk // success pulse
);
  logic [7:0] cnt;
  logic done;
  // fault data toggles to its complement each cycle outside its pulse, so a stale number matches only every other cycle
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      faultValid <= 1'b0;
      fault <= '0;
    end
    else
    begin
      faultValid <= inj;
      fault <= inj ? flt : ~fault;
    end
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n || !restartReq)
    begin
      cnt <= 8'h00;
      done <= 1'b0;
      startOk <= 1'b0;
    end
    else
    begin
      startOk <= !done && !hold && cnt >= dly;
      done <= done || (!hold && cnt >= dly);
      cnt <= cnt + 8'h01;
    end
endmodule

// ===== verif/auto_restart_supervisor_tb_top.sv
// self-checking bench for the restart supervisor with a mode model
// assumes the partner model and a four-cycle time-base tick
`timescale 1ns/100ps
module auto_restart_supervisor_tb_top;
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er, seen, fa;
  logic [7:0] paddr = 8'h00;
  logic [7:0] dly = 8'h08;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, ackIn = 0, motorOn = 0, runCommand = 0, inj = 0, hold = 0;
  logic faultValid, startOk, faultAck, restartReq, restartFailedFault, irq;
  logic [15:0] lfsr = 16'h60fd;
  ars_pkg::ars_fault_type fault, flt = '0;
  int err_count = 0, n_tests = 0, cyc = 0, k;
  int modes[$] = '{0, 1, 4, 6, 14, 16, 26};
  always #2.5 mclk = ~mclk;
  ars_supervisor #(.TICK_CYCLES(4)) DUT (.mclk(mclk), .rst_n(rst_n), .clkEn(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .faultValid(faultValid), .fault(fault), .ackIn(ackIn),
    .motorOn(motorOn), .runCommand(runCommand), .startOk(startOk), .faultAck(faultAck),
    .restartReq(restartReq), .restartFailedFault(restartFailedFault), .irq(irq));
  ars_partner peer (.mclk(mclk), .rst_n(rst_n), .restartReq(restartReq), .inj(inj), .flt(flt),
    .dly(dly), .hold(hold), .faultValid(faultValid), .fault(fault), .startOk(startOk));
  // ----------------------------------------
  // reference model and bus tasks
  // ----------------------------------------
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic logic expR(int m, logic p, logic listed);
    return ((m == 6 || m == 16 || m == 26) && !listed) || ((m == 4 || m == 14) && p);
  endfunction
  task automatic stop_test();
    if (err_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic ack(input logic mo);
    motorOn <= mo;
    ackIn <= 1'b1;
    @(posedge mclk);
    ackIn <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic fire(input logic p, input logic [15:0] n);
    inj <= 1'b1;
    flt <= {p, n};
    @(posedge mclk);
    inj <= 1'b0;
  endtask
  // every mode gets an acknowledge and a run command when no restart shows at once;
  // a locked supervisor gets no acknowledge, so its failure still stands for the check
  task automatic round(input logic p, input logic [15:0] n);
    fire(p, n);
    seen = 0;
    fa = 0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      seen |= restartReq;
      fa |= faultAck;
      if (i == 2)
      begin
        ackIn <= !seen && restartFailedFault !== 1'b1;
        runCommand <= !seen;
      end
      if (i == 3)
        ackIn <= 1'b0;
    end
    while (restartReq === 1'b1) @(posedge mclk);
    runCommand <= 1'b0;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      stop_test();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(8'h00, 32'h300);
    rdc(8'h04, 32'h258);
    rdc(8'h08, 32'h0);
    apb(1'b0, 8'h48, 32'h0);
    chk(er, 1'b1);
    foreach (modes[i])
    begin
      apb(1'b1, 8'h00, 32'(32'h300 | modes[i]));
      k = rnd();
      round(k[0], {4'h8, k[11:0]});
      chk(seen, expR(modes[i], k[0], 1'b0));
      chk(fa, expR(modes[i], k[0], 1'b0) || modes[i] == 1);
    end
    apb(1'b1, 8'h44, 32'h776);
    apb(1'b1, 8'h00, 32'h306);
    round(1'b0, 16'h776);
    chk(seen, expR(6, 1'b0, 1'b1));
    chk(fa, 1'b0);
    round(1'b0, 16'h777);
    chk(seen, expR(6, 1'b0, 1'b0));
    apb(1'b1, 8'h00, 32'h304);
    round(1'b1, 16'h776);
    chk(seen, expR(4, 1'b1, 1'b0));
    apb(1'b1, 8'h00, 32'h306);
    apb(1'b1, 8'h04, 32'h5);
    rdc(8'h04, 32'h5);
    hold <= 1'b1;
    fire(1'b0, 16'h8001);
    k = 0;
    while (restartFailedFault !== 1'b1 && k < 40)
    begin
      @(posedge mclk);
      k++;
    end
    chk(k >= 16 && k <= 30, 1'b1);
    apb(1'b1, 8'h18, 32'h4);
    chk(irq, 1'b1);
    apb(1'b1, 8'h18, 32'h0);
    chk(irq, 1'b0);
    ack(1'b1);
    chk(restartFailedFault, 1'b1);
    ack(1'b0);
    chk(restartFailedFault, 1'b0);
    apb(1'b1, 8'h14, 32'h7);
    rdc(8'h10, 32'h0);
    rdc(8'h14, 32'h0);
    apb(1'b1, 8'h04, 32'h0);
    fire(1'b0, 16'h8002);
    repeat (60) @(posedge mclk);
    chk(restartFailedFault, 1'b0);
    chk(restartReq, 1'b1);
    hold <= 1'b0;
    while (restartReq === 1'b1) @(posedge mclk);
    dly <= 8'h01;
    apb(1'b1, 8'h04, 32'h258);
    apb(1'b1, 8'h08, 32'h3e8);
    apb(1'b1, 8'h00, 32'h106);
    for (k = 1; k <= 3; k++)
    begin
      round(1'b0, 16'h8003);
      chk(restartFailedFault, k == 3);
      chk(fa, k != 3);
    end
    ack(1'b0);
    apb(1'b1, 8'h08, 32'h0);
    repeat (4)
    begin
      round(1'b0, 16'h8004);
      chk(restartFailedFault, 1'b0);
    end
    stop_test();
  end
endmodule
